// file: include/cscr_defines.vh
// Purpose: constants of the clock source configuration register block
// Assumes: one 200 MHz system clock, classic Wishbone with 32-bit data
// Notes: reference clocks and generated clocks are one-cycle enables
//
// Notes on behaviour
// R1 - source select picks FLL, internal or external; code 11 acts as FLL
// R2 - bus divider divides selected source by 1, 2, 4, 8; resets to 2
// R3 - reference divider divides FLL reference by two to the field value
// R4 - software keeps divided reference between 31.25 and 39.0625 kHz
// R5 - internal reference select routes internal reference to FLL when set
// R6 - internal reference output enable gates the internal reference output
// R7 - internal reference runs in stop if keep set and enabled or in use
// R8 - range bit selects high or low external oscillator band
// R9 - gain bit requests high gain or low power oscillator operation
// R10 - FLL off in bypass modes when bit set, unless debug active
// R11 - external source bit requests crystal oscillator or clock input
// R12 - external reference output enable gates the external reference output
// R13 - external reference runs in stop if keep set and enabled or in use
// R14 - eight-bit trim sets internal period, binary weighted, larger is longer
// R15 - extra fine trim bit sits in the status and control register
// R16 - fine trim set lengthens period one smallest step, clear shortens
// R17 - engaged FLL locks to 1024 times the divided reference frequency
// R18 - bus clock runs at half the generated output clock
// R19 - mode and reference status follow selects only after synchronisation
// R20 - source and divider changes never truncate output clock pulses
`ifndef CSCR_DEFINES_VH
`define CSCR_DEFINES_VH

// register byte offsets
`define CSCR_OFS_CTRL1 8'h00
`define CSCR_OFS_CTRL2 8'h04
`define CSCR_OFS_TRIM 8'h08
`define CSCR_OFS_STAT 8'h0C

// reset values
`define CSCR_RST_CTRL1 8'h04
`define CSCR_RST_CTRL2 8'h40
`define CSCR_RST_TRIM 8'h80
`define CSCR_RST_FINE 1'b0
`define CSCR_RST_BUSDIV 2'b01
`define CSCR_RST_IREF 1'b1

// first control register fields
`define CSCR_SRC_HI 7
`define CSCR_SRC_LO 6
`define CSCR_REFDIV_HI 5
`define CSCR_REFDIV_LO 3
`define CSCR_IRSEL 2
`define CSCR_IROE 1
`define CSCR_IRKEEP 0

// second control register fields
`define CSCR_BUSDIV_HI 7
`define CSCR_BUSDIV_LO 6
`define CSCR_RANGE 5
`define CSCR_GAIN 4
`define CSCR_FOFF 3
`define CSCR_ERSEL 2
`define CSCR_EROE 1
`define CSCR_ERKEEP 0

// status and control register fields
`define CSCR_ST_IREF 4
`define CSCR_ST_MODE_HI 3
`define CSCR_ST_MODE_LO 2
`define CSCR_ST_OSCOK 1
`define CSCR_ST_FINE 0

// clock modes
`define CSCR_MODE_FLL 2'b00
`define CSCR_MODE_INT 2'b01
`define CSCR_MODE_EXT 2'b10
`define CSCR_MODE_RSV 2'b11

// timing
`define CSCR_SYS_MHZ 200
`define CSCR_IRC_BASE 5632
`define CSCR_FLL_MULT 25'd1024
`define CSCR_PER_MAX 24'hFFFFFF

`endif

// file: verilog/cscr_clkdiv.v
// Purpose: source mux and bus divider producing output and bus enables
// Assumes: source ticks are one-cycle enables on clk_sys
// Notes: new source and divider are taken at an output boundary, or at once while the current source is dead
`timescale 1ns/1ps
`include "cscr_defines.vh"

module cscr_clkdiv (
	input wire clk_sys,
	input wire rst_n,
	input wire [2:0] src_tick,
	input wire [2:0] src_alive,
	input wire [1:0] mode_req,
	input wire [1:0] div_req,
	output reg [1:0] mode_act_r,
	output wire out_tick,
	output wire bus_tick
);
	reg [1:0] div_act_r;
	reg [2:0] cnt_r;
	reg half_r;
	wire cur_tick;
	wire cur_alive;
	wire [2:0] mask;
	wire boundary;

	// current source among fll, internal and external
	assign cur_tick = src_tick[mode_act_r];
	assign cur_alive = src_alive[mode_act_r];
	assign mask = (3'h1 << div_act_r) - 3'h1;
	assign out_tick = cur_tick && (cnt_r == mask);
	// R18 half rate bus
	assign bus_tick = out_tick && half_r;
	// a dead source can be left at once, a live one only at a boundary
	assign boundary = out_tick || !cur_alive;

	// R20 switch at boundary
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_act_r <= `CSCR_MODE_FLL;
			div_act_r <= `CSCR_RST_BUSDIV;
			cnt_r <= 3'h0;
			half_r <= 1'b0;
		end else begin
			if (boundary) begin
				mode_act_r <= mode_req;
				div_act_r <= div_req;
				cnt_r <= 3'h0;
			end else if (cur_tick) begin
				cnt_r <= cnt_r + 3'h1;
			end
			if (out_tick) begin
				half_r <= !half_r;
			end
		end
	end
endmodule // cscr_clkdiv

// file: verilog/cscr_top.v
// Purpose: clock source control and trim registers with clock enables
// Assumes: ext_ref_in and osc_ready_in are asynchronous pins
// Notes: stop_req and debug_active come from logic on clk_sys
`timescale 1ns/1ps
`include "cscr_defines.vh"

module cscr_top #(
	parameter IRC_BASE_CYCLES = `CSCR_IRC_BASE
) (
	input wire clk_sys,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire ext_ref_in,
	input wire osc_ready_in,
	input wire stop_req,
	input wire background_debug_active,
	output wire internal_ref_clock_out,
	output wire external_ref_clock_out,
	output wire generated_clock_out,
	output wire bus_clock_en,
	output wire fll_clock_en,
	output reg fll_enable_r,
	output reg osc_enable_r,
	output reg osc_high_band_r,
	output reg osc_high_gain_r,
	output reg osc_crystal_r
);
	// registers
	reg [7:0] ctrl1_r;
	reg [7:0] ctrl2_r;
	reg [7:0] trim_r;
	reg fine_r;
	reg [1:0] mode_sync_r;
	reg [1:0] mode_stat_r;
	reg iref_sync_r;
	reg iref_stat_r;
	reg ext_s1_r;
	reg ext_s2_r;
	reg ext_s3_r;
	reg ok_s1_r;
	reg ok_s2_r;
	reg stop_d_r;
	reg pre_int_r;
	reg pre_ext_r;
	reg [13:0] irc_cnt_r;
	reg irc_tick_r;
	reg [6:0] reference_divider_cnt_r;
	reg [23:0] per_cnt_r;
	reg [23:0] period_r;
	reg per_valid_r;
	reg [24:0] acc_r;
	reg fll_tick_r;

	// fields
	wire [1:0] clock_source_select;
	wire [2:0] reference_divider;
	wire internal_ref_select;
	wire internal_ref_output_enable;
	wire internal_ref_stop_keep;
	wire [1:0] bus_divider;
	wire fll_off_in_bypass;
	wire external_ref_source_select;
	wire external_ref_output_enable;
	wire external_ref_stop_keep;
	wire [1:0] mode_req;
	wire [1:0] mode_act;
	wire [1:0] clock_mode_status;
	wire wb_req;
	wire wb_wr;
	wire [13:0] irc_period;
	wire int_run;
	wire ext_run;
	wire int_tick;
	wire ext_tick;
	wire ref_tick;
	wire [6:0] reference_divider_mask;
	wire div_ref_tick;
	wire bypass_mode;
	wire fll_run;
	wire [24:0] acc_sum;
	wire osc_init_done;
	wire [2:0] src_tick;
	wire [2:0] src_alive;
	wire out_tick;
	reg [7:0] rd_byte;

	assign clock_source_select = ctrl1_r[`CSCR_SRC_HI:`CSCR_SRC_LO];
	assign reference_divider = ctrl1_r[`CSCR_REFDIV_HI:`CSCR_REFDIV_LO];
	assign internal_ref_select = ctrl1_r[`CSCR_IRSEL];
	assign internal_ref_output_enable = ctrl1_r[`CSCR_IROE];
	assign internal_ref_stop_keep = ctrl1_r[`CSCR_IRKEEP];
	assign bus_divider = ctrl2_r[`CSCR_BUSDIV_HI:`CSCR_BUSDIV_LO];
	assign fll_off_in_bypass = ctrl2_r[`CSCR_FOFF];
	assign external_ref_source_select = ctrl2_r[`CSCR_ERSEL];
	assign external_ref_output_enable = ctrl2_r[`CSCR_EROE];
	assign external_ref_stop_keep = ctrl2_r[`CSCR_ERKEEP];
	assign clock_mode_status = mode_stat_r;

	// R1 reserved as fll
	assign mode_req = (clock_source_select == `CSCR_MODE_RSV) ?
		`CSCR_MODE_FLL : clock_source_select;

	// wishbone decode, ack one cycle after request
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

	// register writes; reserved bits of the status register ignored
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl1_r <= `CSCR_RST_CTRL1;
			ctrl2_r <= `CSCR_RST_CTRL2;
			trim_r <= `CSCR_RST_TRIM;
			fine_r <= `CSCR_RST_FINE;
		end else if (wb_wr) begin
			case (wb_adr_i)
			`CSCR_OFS_CTRL1: begin
				ctrl1_r <= wb_dat_i[7:0];
			end
			`CSCR_OFS_CTRL2: begin
				ctrl2_r <= wb_dat_i[7:0];
			end
			`CSCR_OFS_TRIM: begin
				trim_r <= wb_dat_i[7:0];
			end
			`CSCR_OFS_STAT: begin
				// R15 fine trim bit
				fine_r <= wb_dat_i[`CSCR_ST_FINE];
			end
			default: begin
				fine_r <= fine_r;
			end
			endcase
		end
	end

	// read mux, unmapped reads as zero
	always @* begin
		rd_byte = 8'h00;
		case (wb_adr_i)
		`CSCR_OFS_CTRL1: rd_byte = ctrl1_r;
		`CSCR_OFS_CTRL2: rd_byte = ctrl2_r;
		`CSCR_OFS_TRIM: rd_byte = trim_r;
		`CSCR_OFS_STAT: begin
			rd_byte[`CSCR_ST_IREF] = iref_stat_r;
			rd_byte[`CSCR_ST_MODE_HI:`CSCR_ST_MODE_LO] = clock_mode_status;
			rd_byte[`CSCR_ST_OSCOK] = osc_init_done;
			rd_byte[`CSCR_ST_FINE] = fine_r;
		end
		default: rd_byte = 8'h00;
		endcase
	end

	// ack and read data register
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= {24'h000000, rd_byte};
			end
		end
	end

	// pin synchronisers and external edge detect
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			ok_s1_r <= 1'b0;
			ok_s2_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_ref_in;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			ok_s1_r <= osc_ready_in;
			ok_s2_r <= ok_s1_r;
		end
	end

	// R19 status two stages behind applied selects
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_sync_r <= `CSCR_MODE_FLL;
			mode_stat_r <= `CSCR_MODE_FLL;
			iref_sync_r <= `CSCR_RST_IREF;
			iref_stat_r <= `CSCR_RST_IREF;
		end else begin
			mode_sync_r <= mode_act;
			mode_stat_r <= mode_sync_r;
			iref_sync_r <= internal_ref_select;
			iref_stat_r <= iref_sync_r;
		end
	end

	// remember which reference was in use at stop entry
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			stop_d_r <= 1'b0;
			pre_int_r <= 1'b0;
			pre_ext_r <= 1'b0;
		end else begin
			stop_d_r <= stop_req;
			if (stop_req && !stop_d_r) begin
				pre_int_r <= internal_ref_select ||
					(mode_stat_r == `CSCR_MODE_INT);
				pre_ext_r <= !internal_ref_select ||
					(mode_stat_r == `CSCR_MODE_EXT);
			end
		end
	end

	// R7 internal stop keep
	assign int_run = stop_req ?
		(internal_ref_stop_keep &&
		(internal_ref_output_enable || pre_int_r)) :
		(internal_ref_output_enable || internal_ref_select ||
		mode_req == `CSCR_MODE_INT);
	// R13 external stop keep
	assign ext_run = stop_req ?
		(external_ref_stop_keep &&
		(external_ref_output_enable || pre_ext_r)) :
		(external_ref_output_enable || !internal_ref_select ||
		mode_req == `CSCR_MODE_EXT);

	// R14 R16 period from trim and fine bit
	assign irc_period = IRC_BASE_CYCLES[13:0] + {5'h00, trim_r, fine_r};

	// internal reference oscillator as a period counter
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			irc_cnt_r <= 14'h0000;
			irc_tick_r <= 1'b0;
		end else if (!int_run) begin
			irc_cnt_r <= 14'h0000;
			irc_tick_r <= 1'b0;
		end else if (irc_cnt_r >= irc_period - 14'h0001) begin
			irc_cnt_r <= 14'h0000;
			irc_tick_r <= 1'b1;
		end else begin
			irc_cnt_r <= irc_cnt_r + 14'h0001;
			irc_tick_r <= 1'b0;
		end
	end

	assign int_tick = irc_tick_r;
	assign ext_tick = ext_run && ext_s2_r && !ext_s3_r;
	// R6 internal output gate
	assign internal_ref_clock_out = int_tick && internal_ref_output_enable;
	// R12 external output gate
	assign external_ref_clock_out = ext_tick && external_ref_output_enable;

	// R5 fll reference route
	assign ref_tick = internal_ref_select ? int_tick : ext_tick;

	// R3 power of two reference divider
	assign reference_divider_mask = (7'h01 << reference_divider) - 7'h01;
	assign div_ref_tick = ref_tick &&
		((reference_divider_cnt_r & reference_divider_mask) == reference_divider_mask);

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			reference_divider_cnt_r <= 7'h00;
		end else if (ref_tick) begin
			reference_divider_cnt_r <= reference_divider_cnt_r + 7'h01;
		end
	end

	// R10 fll off in bypass
	assign bypass_mode = (mode_req != `CSCR_MODE_FLL);
	assign fll_run = !stop_req && !(bypass_mode && fll_off_in_bypass &&
		!background_debug_active);

	// fll reference period measured in system cycles
	always @(posedge clk_sys) begin
		if (!rst_n || !fll_run) begin
			per_cnt_r <= 24'h000000;
			period_r <= 24'h000000;
			per_valid_r <= 1'b0;
		end else if (div_ref_tick) begin
			per_cnt_r <= 24'h000001;
			if (per_cnt_r != 24'h000000) begin
				period_r <= per_cnt_r;
				per_valid_r <= 1'b1;
			end
		end else if (per_cnt_r != `CSCR_PER_MAX &&
			(per_cnt_r != 24'h000000 || per_valid_r)) begin
			per_cnt_r <= per_cnt_r + 24'h000001;
		end
	end

	// R17 multiply reference by 1024
	assign acc_sum = acc_r + `CSCR_FLL_MULT;

	always @(posedge clk_sys) begin
		if (!rst_n || !fll_run || !per_valid_r) begin
			acc_r <= 25'h0000000;
			fll_tick_r <= 1'b0;
			fll_enable_r <= 1'b0;
		end else begin
			fll_enable_r <= 1'b1;
			if (acc_sum >= {1'b0, period_r}) begin
				acc_r <= acc_sum - {1'b0, period_r};
				fll_tick_r <= 1'b1;
			end else begin
				acc_r <= acc_sum;
				fll_tick_r <= 1'b0;
			end
		end
	end

	assign fll_clock_en = fll_tick_r;

	// oscillator control pins
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			osc_enable_r <= 1'b0;
			osc_high_band_r <= 1'b0;
			osc_high_gain_r <= 1'b0;
			osc_crystal_r <= 1'b0;
		end else begin
			osc_enable_r <= ext_run && external_ref_source_select;
			// R8 band select
			osc_high_band_r <= ctrl2_r[`CSCR_RANGE];
			// R9 gain select
			osc_high_gain_r <= ctrl2_r[`CSCR_GAIN];
			// R11 crystal or clock
			osc_crystal_r <= external_ref_source_select;
		end
	end

	// oscillator ready reported only while requested
	assign osc_init_done = ok_s2_r && external_ref_source_select &&
		(external_ref_output_enable || mode_stat_r == `CSCR_MODE_EXT);

	// R1 source ticks, no output in stop
	assign src_tick = stop_req ? 3'b000 :
		{ext_tick, int_tick, fll_tick_r};
	assign src_alive = {ext_run, int_run, fll_run && per_valid_r};

	// R2 bus divider and source mux
	cscr_clkdiv u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.src_tick(src_tick),
		.src_alive(src_alive),
		.mode_req(mode_req),
		.div_req(bus_divider),
		.mode_act_r(mode_act),
		.out_tick(out_tick),
		.bus_tick(bus_clock_en)
	);

	assign generated_clock_out = out_tick;
endmodule // cscr_top

// file: sim/cscr_asserts.sv
// Purpose: port checks of the clock source register block
// Assumes: bound to cscr_top, one clock domain
// Notes: control registers are shadowed from bus writes
`timescale 1ns/1ps
module cscr_asserts #(
	parameter IRC_BASE_CYCLES = 20
) (
	input wire clk_sys,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire stop_req,
	input wire internal_ref_clock_out,
	input wire external_ref_clock_out,
	input wire generated_clock_out,
	input wire bus_clock_en,
	input wire osc_high_band_r,
	input wire osc_high_gain_r,
	input wire osc_crystal_r
);
	reg [7:0] c1_r;
	reg [7:0] c2_r;
	wire wr_take;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// a write is taken on lane 0 while ack is low
	assign wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
		wb_sel_i[0];
	// shadow copies of both control registers
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			c1_r <= 8'h04;
			c2_r <= 8'h40;
		end else if (wr_take && wb_adr_i == 8'h00)
			c1_r <= wb_dat_i[7:0];
		else if (wr_take && wb_adr_i == 8'h04)
			c2_r <= wb_dat_i[7:0];
	end
	// two edges in stop mode
	sequence stop_held;
		stop_req ##1 stop_req;
	endsequence
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o)
		else $error("request not acked next cycle");
	read_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	irc_gate_a: assert property (!c1_r[1] |-> !internal_ref_clock_out)
		else $error("internal ref out while disabled");
	erc_gate_a: assert property (!c2_r[1] && !$past(c2_r[1]) |->
		!external_ref_clock_out)
		else $error("external ref out while disabled");
	// controls are registered one cycle behind the register
	osc_cfg_a: assert property (1'b1 |=> {osc_high_band_r,
		osc_high_gain_r, osc_crystal_r} ==
		{$past(c2_r[5]), $past(c2_r[4]), $past(c2_r[2])})
		else $error("oscillator controls differ from register");
	bus_half_a: assert property (bus_clock_en |-> generated_clock_out)
		else $error("bus tick without output tick");
	stop_quiet_a: assert property (stop_held |->
		!generated_clock_out && !bus_clock_en)
		else $error("output clock in stop");
	// a tick stands one cycle after the keep bit that allowed it
	irc_stop_a: assert property (stop_held |->
		$past(c1_r[0]) || !internal_ref_clock_out)
		else $error("internal ref alive in stop without keep");
endmodule // cscr_asserts
bind cscr_top cscr_asserts #(.IRC_BASE_CYCLES(IRC_BASE_CYCLES)) u_cscr_asserts (
	.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_req,
	.internal_ref_clock_out, .external_ref_clock_out,
	.generated_clock_out, .bus_clock_en, .osc_high_band_r,
	.osc_high_gain_r, .osc_crystal_r
);

// file: sim/cscr_osc_model.sv
// Purpose: external clock pin and oscillator ready model
// Assumes: half period counted in system cycles
// Notes: clock input runs free, crystal only while enabled
`timescale 1ns/1ps
module cscr_osc_model #(
	parameter HALF = 30,
	parameter INIT = 100
) (
	input wire clk_sys,
	input wire osc_enable_r,
	input wire osc_crystal_r,
	output reg ext_ref_in,
	output reg osc_ready_in
);
	integer cnt = 0;
	integer up = 0;
	// pins start low
	initial begin
		ext_ref_in = 1'b0;
		osc_ready_in = 1'b0;
	end
	always @(posedge clk_sys) begin
		if (!osc_crystal_r || osc_enable_r) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				ext_ref_in <= !ext_ref_in;
		end
		up <= (osc_crystal_r && osc_enable_r) ? up + 1 : 0;
		osc_ready_in <= (up >= INIT);
	end
endmodule // cscr_osc_model

// file: sim/test_cscr_top.sv
// Purpose: self-checking bench of the clock source register block
// Assumes: internal base period shortened to 20 cycles
// Notes: oscillator pin model on the far side
`timescale 1ns/1ps
module test_cscr_top;
	localparam IRC = 20;
	localparam HALF = 30;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg wb_cyc_i = 1'b0;
	reg wb_stb_i = 1'b0;
	reg wb_we_i = 1'b0;
	reg [7:0] wb_adr_i = 8'h00;
	reg [3:0] wb_sel_i = 4'hF;
	reg [31:0] wb_dat_i = 32'h00000000;
	reg stop_req = 1'b0;
	reg background_debug_active = 1'b0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, ext_ref_in, osc_ready_in, internal_ref_clock_out;
	wire external_ref_clock_out, generated_clock_out, bus_clock_en;
	wire fll_clock_en, fll_enable_r, osc_enable_r, osc_high_band_r;
	wire osc_high_gain_r, osc_crystal_r;
	wire [4:0] pulses;
	wire [3:0] osc_pins;
	integer bad_count = 0;
	integer comparisons = 0;
	integer n;
	integer k;
	assign pulses = {fll_clock_en, bus_clock_en, generated_clock_out,
		external_ref_clock_out, internal_ref_clock_out};
	// oscillator enable, band, gain and crystal controls
	assign osc_pins = {osc_enable_r, osc_high_band_r, osc_high_gain_r,
		osc_crystal_r};
	cscr_top #(.IRC_BASE_CYCLES(IRC)) u_cscr_top (.clk_sys, .rst_n,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .ext_ref_in, .osc_ready_in, .stop_req,
		.background_debug_active, .internal_ref_clock_out,
		.external_ref_clock_out, .generated_clock_out, .bus_clock_en,
		.fll_clock_en, .fll_enable_r, .osc_enable_r, .osc_high_band_r,
		.osc_high_gain_r, .osc_crystal_r);
	cscr_osc_model #(.HALF(HALF)) u_cscr_osc_model (.clk_sys,
		.osc_enable_r, .osc_crystal_r, .ext_ref_in, .osc_ready_in);
	// 200 MHz system clock
	always #2.5 clk_sys = ~clk_sys;
	// verdict and end of run
	task end_of_test;
		begin
			$display("comparisons %0d bad_count %0d", comparisons, bad_count);
			if (bad_count == 0 && comparisons > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// compare one value
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("wrong value at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	// one classic bus cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		integer i;
		begin
			@(posedge clk_sys);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= {24'h000000, d};
			for (i = 0; i < 20 && wb_ack_o !== 1'b1; i = i + 1)
				@(posedge clk_sys);
			if (i == 20) begin
				bad_count = bad_count + 1;
				end_of_test;
			end
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
		end
	endtask
	// register write and checked read
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		begin
			wb(1'b0, a, 8'h00, q);
			chk(q, e);
		end
	endtask
	// spacing of the third pulse after the second
	task per(input integer s, output integer n);
		integer i, j, t;
		begin
			n = 0;
			j = 0;
			t = 0;
			for (i = 0; i < 20000 && j < 3; i = i + 1) begin
				@(posedge clk_sys);
				if (pulses[s] === 1'b1) begin
					j = j + 1;
					n = i - t;
					t = i;
				end
			end
		end
	endtask
	// pulses seen in a window
	task cnt(input integer s, input integer len, output integer n);
		integer i;
		begin
			n = 0;
			for (i = 0; i < len; i = i + 1) begin
				@(posedge clk_sys);
				if (pulses[s] === 1'b1)
					n = n + 1;
			end
		end
	endtask
	// reset values, status and unmapped place
	task t_reset;
		begin
			repeat (4) @(posedge clk_sys);
			rd(8'h00, 32'h04);
			rd(8'h04, 32'h40);
			rd(8'h08, 32'h80);
			rd(8'h0C, 32'h10);
			rd(8'h10, 32'h00);
			$display("test reset done");
		end
	endtask
	// oscillator controls and read-only status bits
	task t_regs;
		begin
			wr(8'h04, 8'h36);
			rd(8'h04, 32'h36);
			// wait out oscillator start-up and the ready synchroniser
			repeat (120) @(posedge clk_sys);
			chk({28'h0, osc_pins}, 15);
			wr(8'h0C, 8'hFF);
			rd(8'h0C, 32'h13);
			wr(8'h0C, 8'h00);
			wr(8'h04, 8'h40);
			repeat (3) @(posedge clk_sys);
			chk({28'h0, osc_pins}, 0);
			$display("test regs done");
		end
	endtask
	// internal period from trim and fine trim
	task t_trim;
		begin
			wr(8'h00, 8'h06);
			wr(8'h08, 8'h01);
			per(0, n);
			chk(n, IRC + 2);
			wr(8'h0C, 8'h01);
			per(0, n);
			chk(n, IRC + 3);
			wr(8'h0C, 8'h00);
			wr(8'h08, 8'h02);
			per(0, n);
			chk(n, IRC + 4);
			wr(8'h00, 8'h04);
			cnt(0, 100, n);
			chk(n, 0);
			$display("test trim done");
		end
	endtask
	// internal source through every bus divider code
	task t_busdiv;
		begin
			wr(8'h00, 8'h46);
			for (k = 0; k < 4; k = k + 1) begin
				wr(8'h04, {k[1:0], 6'h00});
				per(2, n);
				chk(n, (IRC + 4) << k);
				per(3, n);
				chk(n, (IRC + 4) << (k + 1));
			end
			$display("test busdiv done");
		end
	endtask
	// external clock input as output and as source
	task t_ext;
		begin
			wr(8'h04, 8'h02);
			per(1, n);
			chk(n, 2 * HALF);
			wr(8'h00, 8'h80);
			per(2, n);
			chk(n, 2 * HALF);
			rd(8'h0C, 32'h08);
			wr(8'h04, 8'h00);
			cnt(1, 200, n);
			chk(n, 0);
			$display("test ext done");
		end
	endtask
	// stop with and without keep
	task t_stop;
		begin
			wr(8'h00, 8'h47);
			wr(8'h04, 8'h43);
			stop_req <= 1'b1;
			cnt(0, 100, n);
			chk({31'h0, n >= 4}, 1);
			cnt(2, 100, n);
			chk(n, 0);
			cnt(1, 200, n);
			chk({31'h0, n >= 3}, 1);
			wr(8'h00, 8'h46);
			cnt(0, 100, n);
			chk(n, 0);
			wr(8'h04, 8'h42);
			cnt(1, 100, n);
			chk(n, 0);
			stop_req <= 1'b0;
			$display("test stop done");
		end
	endtask
	// FLL off in bypass, debug override, lock ratio
	task t_fll;
		begin
			// period 44 cycles, over 128 gives about 35.5 kHz
			wr(8'h08, 8'h0C);
			wr(8'h04, 8'h08);
			wr(8'h00, 8'h7C);
			cnt(2, 100, n);
			chk({31'h0, fll_enable_r}, 0);
			background_debug_active <= 1'b1;
			for (k = 0; k < 20000 && fll_enable_r !== 1'b1; k = k + 1)
				@(posedge clk_sys);
			chk({31'h0, fll_enable_r}, 1);
			background_debug_active <= 1'b0;
			wr(8'h00, 8'hFC);
			rd(8'h00, 32'hFC);
			per(2, n);
			cnt(2, 128 * (IRC + 24), n);
			chk({31'h0, n >= 1022 && n <= 1026}, 1);
			cnt(4, 128 * (IRC + 24), n);
			chk({31'h0, n >= 1022 && n <= 1026}, 1);
			$display("test fll done");
		end
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset;
		t_regs;
		t_trim;
		t_busdiv;
		t_ext;
		t_stop;
		t_fll;
		end_of_test;
	end
endmodule // test_cscr_top
